// file: hdl/lsi_pkg.sv
// Package for the link status indicator block: timing, config ROM
// layout, mapping codes and the carrier structs shared by its ports.
// Assumes a single 20 MHz clock domain; no software-visible registers.
package lsi_pkg;

  // Clock
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // Blink rates in Hz and the half period of each in clock cycles
  localparam int ACT_BLINK_HZ    = 10;
  localparam int COL_BLINK_HZ    = 20;
  localparam int ACT_HALF_CYCLES = CLK_HZ / (2 * ACT_BLINK_HZ);
  localparam int COL_HALF_CYCLES = CLK_HZ / (2 * COL_BLINK_HZ);

  // Serial ROM clock: least half period, rounded up to whole cycles
  localparam int ROM_SK_HALF_NS     = 500;
  localparam int ROM_SK_HALF_CYCLES =
    (ROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial ROM read command: start bit, read opcode, word address
  localparam logic [2:0] ROM_READ_CMD   = 3'h6;
  localparam logic [5:0] CFG_WORD_ADDR  = 6'h0B;
  localparam int         ROM_CMD_BITS   = 9;
  localparam int         ROM_DATA_BITS  = 16;
  localparam int         MAP_FIELD_LO   = 6;
  localparam int         MAP_FIELD_W    = 2;

  // External PHY select code in the PHY select field
  localparam logic [2:0] EXT_PHY_CODE = 3'h1;

  // Indicator levels: lit is driven low
  localparam logic IND_LIT  = 1'h0;
  localparam logic IND_DARK = 1'h1;

  // Indicator lanes
  localparam int IND_SPEED  = 0;
  localparam int IND_LINK   = 1;
  localparam int IND_DUPLEX = 2;

  // Display mappings
  typedef enum logic [1:0] {
    LSI_MAP_DEFAULT = 2'h0,
    LSI_MAP_ALT     = 2'h1
  } lsi_map_t;

  // PHY state presented to the block
  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic full_duplex;
    logic rx_active;
    logic tx_active;
    logic collision;
  } lsi_phy_state_t;

  // Three indicator pins; oe_n low while the block drives them
  typedef struct packed {
    logic [2:0] level;
    logic       oe_n;
  } lsi_ind_t;

  // Serial ROM pins driven by the block
  typedef struct packed {
    logic select;
    logic serial_clock;
    logic command_out;
  } lsi_rom_out_t;

endpackage

// file: hdl/lsi_link_status_indicator.sv
// Link status indicator: drives speed, link/activity and duplex/collision
// indicators from the PHY state, in one of two mappings read from the
// serial configuration ROM after reset.
// Assumes PHY state and ROM data input are synchronous to clock.
`timescale 1ns/1ps

module lsi_link_status_indicator #(
  parameter int ACT_HALF = lsi_pkg::ACT_HALF_CYCLES,
  parameter int COL_HALF = lsi_pkg::COL_HALF_CYCLES,
  parameter int SK_HALF  = lsi_pkg::ROM_SK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // PHY state and PHY select field
  input  wire lsi_pkg::lsi_phy_state_t phy,
  input  wire logic [2:0]            phy_select,
  // Load configuration from the ROM after reset
  input  wire logic                  cfg_load_enable,
  // Serial configuration ROM
  output lsi_pkg::lsi_rom_out_t      cfg_rom,
  input  wire logic                  cfg_rom_data_in,
  // Indicator pins and load status
  output lsi_pkg::lsi_ind_t          indicators,
  output logic                       cfg_loaded
);
  import lsi_pkg::*;

  localparam int ACT_W = $clog2(ACT_HALF + 1);
  localparam int COL_W = $clog2(COL_HALF + 1);
  localparam int SK_W  = $clog2(SK_HALF + 1);
  localparam int BIT_W = $clog2(ROM_DATA_BITS + 1);

  typedef enum logic [1:0] {ROM_IDLE, ROM_CMD, ROM_READ, ROM_DONE} lsi_rom_state_t;

  // Undefined codes fall back to the default mapping
  function automatic lsi_map_t map_decode(input logic [ROM_DATA_BITS-1:0] word);
    logic [MAP_FIELD_W-1:0] field;
    field = word[MAP_FIELD_LO +: MAP_FIELD_W];
    map_decode = (field == LSI_MAP_ALT) ? LSI_MAP_ALT : LSI_MAP_DEFAULT;
  endfunction

  // Loader state
  lsi_rom_state_t             st_reg,    st_next;
  logic [SK_W-1:0]            half_reg,  half_next;
  logic                       sk_reg,    sk_next;
  logic                       cs_reg,    cs_next;
  logic                       di_reg,    di_next;
  logic [BIT_W-1:0]           bit_reg,   bit_next;
  logic [ROM_CMD_BITS-1:0]    cmd_reg,   cmd_next;
  logic [ROM_DATA_BITS-1:0]   word_reg,  word_next;
  lsi_map_t                   map_reg,   map_next;
  logic                       half_wrap;

  assign half_wrap = (half_reg == SK_W'(SK_HALF - 1));

  // Loader next state: ROM clock low half presents a bit, data sampled
  // at the end of the high half so it has settled a full half period
  always_comb begin
    st_next   = st_reg;
    half_next = half_reg;
    sk_next   = sk_reg;
    cs_next   = cs_reg;
    di_next   = di_reg;
    bit_next  = bit_reg;
    cmd_next  = cmd_reg;
    word_next = word_reg;
    map_next  = map_reg;
    unique case (st_reg)
      ROM_IDLE: begin
        if (cfg_load_enable) begin
          st_next  = ROM_CMD;
          cs_next  = 1'h1;
          di_next  = ROM_READ_CMD[2];
          cmd_next = {ROM_READ_CMD[1:0], CFG_WORD_ADDR, 1'h0};
          bit_next = '0;
          half_next = '0;
        end else begin
          st_next = ROM_DONE;
        end
      end
      ROM_CMD, ROM_READ: begin
        half_next = half_wrap ? '0 : SK_W'(half_reg + 1'b1);
        if (half_wrap) begin
          sk_next = ~sk_reg;
          if (sk_reg && st_reg == ROM_CMD) begin
            if (bit_reg == BIT_W'(ROM_CMD_BITS - 1)) begin
              st_next  = ROM_READ;
              bit_next = '0;
              di_next  = 1'h0;
            end else begin
              di_next  = cmd_reg[ROM_CMD_BITS-1];
              cmd_next = {cmd_reg[ROM_CMD_BITS-2:0], 1'h0};
              bit_next = BIT_W'(bit_reg + 1'b1);
            end
          end else if (sk_reg) begin
            word_next = {word_reg[ROM_DATA_BITS-2:0], cfg_rom_data_in};
            if (bit_reg == BIT_W'(ROM_DATA_BITS - 1)) begin
              st_next  = ROM_DONE;
              cs_next  = 1'h0;
              map_next = map_decode({word_reg[ROM_DATA_BITS-2:0], cfg_rom_data_in});
            end else begin
              bit_next = BIT_W'(bit_reg + 1'b1);
            end
          end
        end
      end
      ROM_DONE: begin
        sk_next = 1'h0;
        di_next = 1'h0;
      end
    endcase
  end

  // Loader registers; mapping stays default until the load ends
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg   <= ROM_IDLE;
      half_reg <= '0;
      sk_reg   <= 1'h0;
      cs_reg   <= 1'h0;
      di_reg   <= 1'h0;
      bit_reg  <= '0;
      cmd_reg  <= '0;
      word_reg <= '0;
      map_reg  <= LSI_MAP_DEFAULT;
    end else begin
      st_reg   <= st_next;
      half_reg <= half_next;
      sk_reg   <= sk_next;
      cs_reg   <= cs_next;
      di_reg   <= di_next;
      bit_reg  <= bit_next;
      cmd_reg  <= cmd_next;
      word_reg <= word_next;
      map_reg  <= map_next;
    end
  end

  assign cfg_rom.select       = cs_reg;
  assign cfg_rom.serial_clock = sk_reg;
  assign cfg_rom.command_out  = di_reg;
  assign cfg_loaded           = (st_reg == ROM_DONE);

  // Blink generators: free running so lamps on the same generator share phase
  logic [ACT_W-1:0] act_cnt_reg, act_cnt_next;
  logic [COL_W-1:0] col_cnt_reg, col_cnt_next;
  logic             act_ph_reg,  act_ph_next;
  logic             col_ph_reg,  col_ph_next;

  always_comb begin
    act_cnt_next = ACT_W'(act_cnt_reg + 1'b1);
    act_ph_next  = act_ph_reg;
    if (act_cnt_reg == ACT_W'(ACT_HALF - 1)) begin
      act_cnt_next = '0;
      act_ph_next  = ~act_ph_reg;
    end
    col_cnt_next = COL_W'(col_cnt_reg + 1'b1);
    col_ph_next  = col_ph_reg;
    if (col_cnt_reg == COL_W'(COL_HALF - 1)) begin
      col_cnt_next = '0;
      col_ph_next  = ~col_ph_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      act_cnt_reg <= '0;
      col_cnt_reg <= '0;
      act_ph_reg  <= 1'h0;
      col_ph_reg  <= 1'h0;
    end else begin
      act_cnt_reg <= act_cnt_next;
      col_cnt_reg <= col_cnt_next;
      act_ph_reg  <= act_ph_next;
      col_ph_reg  <= col_ph_next;
    end
  end

  // Indicator mapping
  lsi_ind_t ind_reg, ind_next;
  logic     traffic;
  logic     ext_phy;

  assign traffic = phy.link_up && (phy.rx_active || phy.tx_active);
  assign ext_phy = (phy_select == EXT_PHY_CODE);

  always_comb begin
    ind_next.oe_n = ext_phy;
    if (map_reg == LSI_MAP_ALT) begin
      ind_next.level[IND_SPEED]  = traffic ? act_ph_reg : IND_DARK;
      ind_next.level[IND_LINK]   = (phy.link_up && !phy.speed_100) ? IND_LIT : IND_DARK;
      ind_next.level[IND_DUPLEX] = (phy.link_up && phy.speed_100) ? IND_LIT : IND_DARK;
    end else begin
      ind_next.level[IND_SPEED] = phy.speed_100 ? IND_LIT : IND_DARK;
      if (traffic && !phy.collision) begin
        ind_next.level[IND_LINK] = act_ph_reg;
      end else begin
        ind_next.level[IND_LINK] = phy.link_up ? IND_LIT : IND_DARK;
      end
      if (phy.collision && !phy.full_duplex) begin
        ind_next.level[IND_DUPLEX] = col_ph_reg;
      end else begin
        ind_next.level[IND_DUPLEX] = phy.full_duplex ? IND_LIT : IND_DARK;
      end
    end
  end

  // Registered pins; floated from reset until the first edge decides
  always_ff @(posedge clock) begin
    if (rst) begin
      ind_reg <= '{level: 3'h7, oe_n: 1'h1};
    end else begin
      ind_reg <= ind_next;
    end
  end

  assign indicators = ind_reg;

  // Checks
  property p_speed_default;
    @(posedge clock) disable iff (rst)
      (map_reg == LSI_MAP_DEFAULT) |=> (ind_reg.level[IND_SPEED] == !$past(phy.speed_100));
  endproperty
  a_speed_default: assert property (p_speed_default) else $error("speed lamp wrong");

  property p_link_steady;
    @(posedge clock) disable iff (rst)
      (map_reg == LSI_MAP_DEFAULT && phy.link_up && !phy.rx_active && !phy.tx_active)
      |=> (ind_reg.level[IND_LINK] == IND_LIT);
  endproperty
  a_link_steady: assert property (p_link_steady) else $error("link lamp not lit");

  property p_duplex_full;
    @(posedge clock) disable iff (rst)
      (map_reg == LSI_MAP_DEFAULT && phy.full_duplex)
      |=> (ind_reg.level[IND_DUPLEX] == IND_LIT);
  endproperty
  a_duplex_full: assert property (p_duplex_full) else $error("duplex lamp not lit");

  property p_act_hold;
    @(posedge clock) disable iff (rst)
      (act_cnt_reg != ACT_W'(ACT_HALF - 1)) |=> $stable(act_ph_reg);
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("activity blink early");

  property p_col_flip;
    @(posedge clock) disable iff (rst)
      (col_cnt_reg == COL_W'(COL_HALF - 1)) |=> (col_ph_reg != $past(col_ph_reg));
  endproperty
  a_col_flip: assert property (p_col_flip) else $error("collision blink missed");

  property p_map_load;
    @(posedge clock) disable iff (rst)
      (st_reg == ROM_READ && st_next == ROM_DONE) |=> (cfg_loaded && !cs_reg);
  endproperty
  a_map_load: assert property (p_map_load) else $error("load end wrong");

  property p_alt_map;
    @(posedge clock) disable iff (rst)
      (map_reg == LSI_MAP_ALT && phy.link_up && !phy.speed_100)
      |=> (ind_reg.level[IND_LINK] == IND_LIT && ind_reg.level[IND_DUPLEX] == IND_DARK);
  endproperty
  a_alt_map: assert property (p_alt_map) else $error("alt mapping wrong");

  property p_float;
    @(posedge clock) disable iff (rst)
      1'b1 |=> (ind_reg.oe_n == ($past(phy_select) == EXT_PHY_CODE));
  endproperty
  a_float: assert property (p_float) else $error("float control wrong");

  property p_select_only_loading;
    @(posedge clock) disable iff (rst)
      cs_reg |-> (st_reg == ROM_CMD || st_reg == ROM_READ);
  endproperty
  a_select_only_loading: assert property (p_select_only_loading)
    else $error("select stray");

  property p_default_before_load;
    @(posedge clock) disable iff (rst)
      !cfg_loaded |-> (map_reg == LSI_MAP_DEFAULT);
  endproperty
  a_default_before_load: assert property (p_default_before_load) else $error("map early");

  property p_sk_idle;
    @(posedge clock) disable iff (rst)
      (st_reg == ROM_DONE) |=> !sk_reg;
  endproperty
  a_sk_idle: assert property (p_sk_idle) else $error("rom clock runs idle");

  c_load_done: cover property (@(posedge clock) disable iff (rst)
                               $rose(cfg_loaded) && cfg_load_enable);
  c_alt_used:  cover property (@(posedge clock) disable iff (rst) map_reg == LSI_MAP_ALT);
  c_collide:   cover property (@(posedge clock) disable iff (rst)
                               phy.collision && !phy.full_duplex && $changed(col_ph_reg));
  c_floated:   cover property (@(posedge clock) disable iff (rst) ind_reg.oe_n);

endmodule

// file: sim/lsi_rom_model.sv
// Behavioural serial configuration ROM facing the indicator block.
// Assumes the block sends 9 command bits on serial clock rises and reads
// 16 data bits MSB first at each fall.
`timescale 1ns/1ps

module lsi_rom_model (
  // Pins from the block
  input  wire lsi_pkg::lsi_rom_out_t rom,
  // Word held at the configuration address
  input  wire logic [15:0]           rom_word,
  // Data pin back to the block
  output logic                       data_out,
  // High once a read of the configuration word was seen
  output logic                       cmd_ok
);
  import lsi_pkg::*;

  logic [4:0] bit_cnt   = 5'h00;
  logic [8:0] cmd_shift = 9'h000;
  logic       data_q    = 1'h0;

  initial cmd_ok = 1'h0;

  // Shift in the command, then present one data bit per serial clock rise
  always @(posedge rom.serial_clock or negedge rom.select) begin
    if (!rom.select) begin
      bit_cnt <= 5'h00;
    end else begin
      if (bit_cnt == 5'h00) begin
        cmd_ok <= 1'h0;
      end
      if (bit_cnt < 5'h09) begin
        cmd_shift <= {cmd_shift[7:0], rom.command_out};
      end else begin
        data_q <= rom_word[15 - (int'(bit_cnt) - 9)];
      end
      if (bit_cnt == 5'h09) begin
        cmd_ok <= (cmd_shift == {ROM_READ_CMD, CFG_WORD_ADDR});
      end
      if (bit_cnt < 5'h19) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // The data pin has a pull-down, so it reads low while not driven
  assign data_out = (rom.select && bit_cnt > 5'h09) ? data_q : 1'h0;

endmodule

// file: sim/lsi_link_status_indicator_test.sv
// Testbench for the link status indicator: both mappings, blink periods,
// tri-state and the configuration ROM load.
// Assumes lsi_rom_model answers the serial ROM read.
`timescale 1ns/1ps

module lsi_link_status_indicator_test;
  import lsi_pkg::*;

  // Short blink counts keep the run brief
  localparam int ACT = 8;
  localparam int COL = 4;

  logic           clock;
  logic           rst;
  lsi_phy_state_t phy;
  logic [2:0]     phy_select;
  logic           cfg_load_enable;
  lsi_rom_out_t   cfg_rom;
  logic           cfg_rom_data_in;
  lsi_ind_t       indicators;
  logic           cfg_loaded;
  logic [15:0]    rom_word;
  logic           cmd_ok;
  int             bad_count;
  int             compares;

  lsi_link_status_indicator #(.ACT_HALF(ACT), .COL_HALF(COL), .SK_HALF(2))
    lsi_link_status_indicator_inst (
    .clock(clock), .rst(rst), .phy(phy), .phy_select(phy_select),
    .cfg_load_enable(cfg_load_enable), .cfg_rom(cfg_rom),
    .cfg_rom_data_in(cfg_rom_data_in), .indicators(indicators), .cfg_loaded(cfg_loaded));

  lsi_rom_model lsi_rom_model_inst (
    .rom(cfg_rom), .rom_word(rom_word), .data_out(cfg_rom_data_in), .cmd_ok(cmd_ok));

  // 20 MHz clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Inputs move a fixed 5 ns after a rising edge, clear of the sampling edge
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #5;
  endtask

  task automatic set_phy(logic [5:0] v);
    phy = v;
    tick();
  endtask

  // Reset, then wait a bounded time for the loader to finish
  task automatic do_reset(logic load, logic [15:0] word);
    rst = 1'h1;
    cfg_load_enable = load;
    rom_word = word;
    phy = 6'h38;
    tick(16);
    check("ind_reset", {indicators.level, indicators.oe_n}, 8'h0F);
    check("rom_reset", {5'h00, cfg_rom}, 8'h00);
    rst = 1'h0;
    for (int i = 0; i < 400 && cfg_loaded !== 1'h1; i++) begin
      tick();
      if (i == 0 || !load) check("rom_select", cfg_rom.select, load);
      if (i == 2) check("map_before_load", indicators.level, 3'h0);
    end
    if (cfg_loaded !== 1'h1) begin
      bad_count++;
      test_done();
    end
    check("select_after", cfg_rom.select, 1'h0);
    if (load) check("rom_read", cmd_ok, 1'h1);
    tick(2);
  endtask

  // Time one half period of a blinking lamp, bounded
  task automatic half_period(int lane, int exp, string name);
    logic prev;
    int   n;
    prev = indicators.level[lane];
    n = 0;
    for (int i = 0; i < 4 * exp && indicators.level[lane] === prev; i++) tick();
    prev = indicators.level[lane];
    while (n < 4 * exp && indicators.level[lane] === prev) begin
      tick();
      n++;
    end
    check(name, 8'(n), 8'(exp));
  endtask

  // Default mapping: steady levels, activity and collision blinking
  task automatic test_default();
    do_reset(1'h0, 16'h0000);
    set_phy(6'h38);
    check("dflt_100_full", indicators.level, 3'h0);
    set_phy(6'h10);
    check("dflt_10_half", indicators.level, 3'h5);
    set_phy(6'h00);
    check("dflt_down", indicators.level, 3'h7);
    set_phy(6'h19);
    check("dflt_col_full", indicators.level, 3'h1);
    set_phy(6'h14);
    half_period(IND_LINK, ACT, "act_blink");
    set_phy(6'h13);
    check("act_with_col", indicators.level[IND_LINK], 1'h0);
    half_period(IND_DUPLEX, COL, "col_blink");
  endtask

  // Every PHY select code; only the external one floats the lamps
  task automatic test_float();
    for (int c = 0; c < 8; c++) begin
      phy_select = 3'(c);
      tick();
      check("oe_n", indicators.oe_n, 1'(c == 1));
    end
    phy_select = 3'h0;
  endtask

  // Alternate mapping from field 01, other word bits set
  task automatic test_alt();
    do_reset(1'h1, 16'hA57F);
    set_phy(6'h10);
    check("alt_10", indicators.level, 3'h5);
    set_phy(6'h30);
    check("alt_100", indicators.level, 3'h3);
    set_phy(6'h08);
    check("alt_down", indicators.level, 3'h7);
    set_phy(6'h34);
    half_period(IND_SPEED, ACT, "alt_act");
  endtask

  // Undefined field code 10 falls back to the default mapping
  task automatic test_odd_code();
    do_reset(1'h1, 16'h5A80);
    set_phy(6'h38);
    check("odd_code", indicators.level, 3'h0);
    set_phy(6'h10);
    check("odd_code_10", indicators.level, 3'h5);
  endtask

  initial begin
    bad_count = 0;
    compares = 0;
    rst = 1'h1;
    phy = 6'h00;
    phy_select = 3'h0;
    cfg_load_enable = 1'h0;
    rom_word = 16'h0000;
    test_default();
    test_float();
    test_alt();
    test_odd_code();
    test_done();
  end

endmodule
